// file: dv/dtmr_monitor.sv
// Checker of transmit lane timing and receive settle masks
`timescale 1ns/1ns
module dtmr_monitor (
  input wire logic                        clk_sys_i,     // System clock
  input wire logic                        rst_n_i,       // Reset, active low
  input wire logic                        clk_link_i,    // Link clock
  input wire logic                        rx_clk_prep_i, // Clock lane preparation
  input wire logic                        rx_dat_prep_i, // Data lane preparation
  input wire dphy_tmr_pkg::dtmr_tx_lane_t tx_lane_o,     // Lane states
  input wire dphy_tmr_pkg::dtmr_rx_mask_t rx_mask_o      // Settle masks
);
  // ==========================================================================
  // Length of each lane state and of each mask window
  // ==========================================================================
  logic [2:0]  cp;
  logic [2:0]  dp;
  logic [11:0] cn;
  logic [11:0] dn;
  logic [11:0] mc;
  logic [11:0] md;
  wire  [2:0]  cl = tx_lane_o.clk_line;
  wire  [2:0]  dl = tx_lane_o.dat_line;
  wire         cx = cl != cp;
  wire         dx = dl != dp;
  always_ff @(posedge clk_sys_i) begin
    cp <= rst_n_i ? cl : 3'h0;
    dp <= rst_n_i ? dl : 3'h0;
    cn <= (!rst_n_i || cx) ? 12'h0_001 : cn + 12'h0_001;
    dn <= (!rst_n_i || dx) ? 12'h0_001 : dn + 12'h0_001;
  end
  always_ff @(posedge clk_link_i) begin
    mc <= rx_mask_o.clk_mask ? mc + 12'h0_001 : 12'h0_000;
    md <= rx_mask_o.dat_mask ? md + 12'h0_001 : 12'h0_000;
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_lp_order: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (cx && cl == dphy_tmr_pkg::DTMR_LP00) |-> cp == dphy_tmr_pkg::DTMR_LP01)
    else $error("clock lane entered LP-00 not from LP-01");
  a_lpx_len: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (dx && dp == dphy_tmr_pkg::DTMR_LP01) |-> dn >= 12'h0_005)
    else $error("data lane LP-01 shorter than 50 ns");
  a_clk_prep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (cx && cp == dphy_tmr_pkg::DTMR_LP00) |-> cn == 12'h0_005 && cl == dphy_tmr_pkg::DTMR_HS0)
    else $error("clock lane LP-00 length wrong");
  a_clk_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (cx && cp == dphy_tmr_pkg::DTMR_HS0 && cl == dphy_tmr_pkg::DTMR_HSTX) |-> cn == 12'h0_01A)
    else $error("clock lane HS-0 before clock start wrong");
  a_clk_lead: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (dx && dp == dphy_tmr_pkg::DTMR_LP11) |->
    $past(tx_lane_o.hs_clk_en, 2) && $past(tx_lane_o.hs_clk_en))
    else $error("data lane left LP-11 before 8 UI of clock");
  a_dat_prep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (dx && dp == dphy_tmr_pkg::DTMR_LP00) |-> dn == 12'h0_007 && dl == dphy_tmr_pkg::DTMR_HS0)
    else $error("data lane LP-00 length wrong");
  a_dat_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (dx && dp == dphy_tmr_pkg::DTMR_HS0) |-> dn == 12'h0_00E && dl == dphy_tmr_pkg::DTMR_HSTX)
    else $error("data lane HS-0 before sync wrong");
  a_dat_trail: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (dx && dp == dphy_tmr_pkg::DTMR_TRL) |-> dn == 12'h0_007 && dl == dphy_tmr_pkg::DTMR_LP11)
    else $error("data trail length or exit state wrong");
  a_clk_post: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (cx && cp == dphy_tmr_pkg::DTMR_HSTX) |-> dl == dphy_tmr_pkg::DTMR_LP11 && dn >= 12'h0_011)
    else $error("clock stopped too soon after data trail");
  a_clk_trail: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (cx && cp == dphy_tmr_pkg::DTMR_HS0 && cl == dphy_tmr_pkg::DTMR_LP11) |-> cn >= 12'h0_006)
    else $error("clock trail shorter than 60 ns");
  a_mask_start: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
    $rose(rx_clk_prep_i) |-> ##[2:4] rx_mask_o.clk_mask)
    else $error("clock settle mask did not start");
  a_clk_settle: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
    $fell(rx_mask_o.clk_mask) |-> mc == 12'h0_010)
    else $error("clock settle window length wrong");
  a_dat_settle: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
    $fell(rx_mask_o.dat_mask) |-> md == 12'h0_00A)
    else $error("data settle window length wrong");
  c_burst: cover property (@(posedge clk_sys_i) dx && dp == dphy_tmr_pkg::DTMR_TRL);
  c_clk_win: cover property (@(posedge clk_link_i) $fell(rx_mask_o.clk_mask));
  c_dat_win: cover property (@(posedge clk_link_i) $fell(rx_mask_o.dat_mask));
endmodule

bind dtmr_top dtmr_monitor u_dtmr_monitor (.clk_sys_i, .rst_n_i, .clk_link_i, .rx_clk_prep_i,
  .rx_dat_prep_i, .tx_lane_o, .rx_mask_o);

// file: dv/dtmr_peer_model.sv
// Peer transmitter model driving the lane preparation levels on the link clock
`timescale 1ns/1ns
module dtmr_peer_model (
  input  wire logic clk_link_i,  // Link clock
  input  wire logic go_clk_i,    // Start clock lane preparation
  input  wire logic go_dat_i,    // Start data lane preparation
  output logic      clk_prep_o,  // Clock lane in LP-00
  output logic      dat_prep_o   // Data lane in LP-00
);
  logic [3:0] ct = 4'h0;
  logic [3:0] dt = 4'h0;

  // LP-00 holds 5 link cycles (60 ns), then the lane leaves for HS-0
  always @(posedge clk_link_i) begin
    ct <= go_clk_i ? 4'h5 : ((ct != 4'h0) ? ct - 4'h1 : 4'h0);
    dt <= go_dat_i ? 4'h5 : ((dt != 4'h0) ? dt - 4'h1 : 4'h0);
  end
  assign clk_prep_o = ct != 4'h0;
  assign dat_prep_o = dt != 4'h0;
endmodule

// file: dv/tb.sv
// Self-checking bench of the lane transition timer
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb;
  logic clk_sys_i  = 1'b0;
  logic clk_link_i = 1'b0;
  logic rst_n_i    = 1'b0;
  logic tx_req_i   = 1'b0;
  logic tx_last_i  = 1'b0;
  logic req_cmd    = 1'b0;
  logic last_cmd   = 1'b0;
  logic go_clk     = 1'b0;
  logic go_dat     = 1'b0;
  logic clk_prep;
  logic dat_prep;
  logic busy;
  int   err_count    = 0;
  int   total_checks = 0;
  int   n_last;
  int   lp11_n       = 0;
  dphy_tmr_pkg::dtmr_tx_lane_t lane;
  dphy_tmr_pkg::dtmr_rx_mask_t mask;
  localparam int UI = 2000;

  dtmr_top #(.UI_PS(UI), .CLK_SETTLE_NS(200), .HS_SETTLE_NS(120)) u_dtmr_top (.clk_sys_i,
    .rst_n_i, .clk_link_i, .tx_req_i, .tx_last_i, .rx_clk_prep_i(clk_prep),
    .rx_dat_prep_i(dat_prep), .tx_lane_o(lane), .tx_busy_o(busy), .rx_mask_o(mask));
  dtmr_peer_model u_dtmr_peer_model (.clk_link_i, .go_clk_i(go_clk), .go_dat_i(go_dat),
    .clk_prep_o(clk_prep), .dat_prep_o(dat_prep));

  initial forever #5 clk_sys_i = ~clk_sys_i;
  initial begin
    #3;
    forever #6 clk_link_i = ~clk_link_i;
  end
  always @(posedge clk_sys_i) begin
    tx_req_i  <= req_cmd;
    tx_last_i <= last_cmd;
    lp11_n    <= (lane.clk_line != dphy_tmr_pkg::DTMR_LP11) ? 0 : lp11_n + 1;
  end

  function automatic int cyc(input int ps);
    return (ps + 9999) / 10000;
  endfunction

  task automatic test_done();
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Waits for a lane state; n_last counts the cycles waited
  task automatic step(input bit dat, input logic [2:0] v, input int exp, input string nm);
    n_last = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      n_last++;
    end while ((dat ? lane.dat_line : lane.clk_line) !== v && n_last < 300);
    if (n_last >= 300) begin
      err_count++;
      test_done();
    end
    if (exp > 0) `CHK(nm, exp, n_last)
  endtask

  task automatic burst_seq(input int hold);
    req_cmd  = 1'b1;
    last_cmd = 1'b1;
    step(0, dphy_tmr_pkg::DTMR_LP01, 0, "idle");
    `CHK("idle lp11", 1'b1, lp11_n >= cyc(50000))
    `CHK("busy", 1'b1, busy)
    step(0, dphy_tmr_pkg::DTMR_LP00, cyc(50000), "clk lp01");
    step(0, dphy_tmr_pkg::DTMR_HS0, cyc(50000), "clk lp00");
    step(0, dphy_tmr_pkg::DTMR_HSTX, cyc(260000), "clk hs0");
    `CHK("clk sum", 1'b1, n_last + cyc(50000) >= cyc(300000))
    `CHK("clk on", 1'b1, lane.hs_clk_en)
    step(1, dphy_tmr_pkg::DTMR_LP01, 0, "clk pre");
    `CHK("clk pre", 1'b1, n_last >= cyc(8 * UI))
    last_cmd = 1'b0;
    step(1, dphy_tmr_pkg::DTMR_LP00, cyc(50000), "dat lp01");
    step(1, dphy_tmr_pkg::DTMR_HS0, cyc(60000 + 5 * UI), "dat lp00");
    step(1, dphy_tmr_pkg::DTMR_HSTX, cyc(120000 + 10 * UI), "dat hs0");
    `CHK("ready", 1'b1, lane.dat_ready)
    repeat (hold) @(posedge clk_sys_i);
    #1;
    `CHK("hs held", dphy_tmr_pkg::DTMR_HSTX, lane.dat_line)
    last_cmd = 1'b1;
    step(1, dphy_tmr_pkg::DTMR_TRL, 0, "dat hs");
    last_cmd = 1'b0;
    step(1, dphy_tmr_pkg::DTMR_LP11, cyc(60000 + 4 * UI), "dat trail");
    step(0, dphy_tmr_pkg::DTMR_HS0, cyc(60000 + 52 * UI), "clk post");
    `CHK("clk off", 1'b0, lane.hs_clk_en)
    step(0, dphy_tmr_pkg::DTMR_LP11, cyc(60000), "clk trail");
  endtask

  // One lane preparation at the peer; n is the mask window in link cycles
  task automatic rx_seq(input bit dat, output int n);
    n = 0;
    @(posedge clk_link_i) {go_dat, go_clk} <= dat ? 2'b10 : 2'b01;
    @(posedge clk_link_i) {go_dat, go_clk} <= 2'b00;
    while (mask[!dat] !== 1'b1 && n < 20) begin
      @(posedge clk_link_i);
      #1;
      n++;
    end
    n = (mask[!dat] === 1'b1) ? 0 : 400;
    while (mask[!dat] === 1'b1 && n < 400) begin
      @(posedge clk_link_i);
      #1;
      n++;
    end
    if (n >= 400) begin
      err_count++;
      test_done();
    end
  endtask

  initial begin
    int w;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    #1;
    `CHK("reset lanes", 8'h00, lane)
    `CHK("reset busy", 1'b0, busy)
    rx_seq(0, w);
    `CHK("clk settle", 200000 / 12000, w)
    rx_seq(1, w);
    `CHK("dat settle", 120000 / 12000, w)
    burst_seq(3);
    burst_seq(0);
    req_cmd = 1'b0;
    repeat (cyc(50000) + 2) @(posedge clk_sys_i);
    #1;
    `CHK("end busy", 1'b0, busy)
    `CHK("end lanes", 8'h00, lane)
    test_done();
  end
endmodule

// file: rtl/dtmr_settle.sv
// Receive settle window generator on the link clock
`timescale 1ns/1ns
module dtmr_settle #(
  parameter logic [11:0] SETTLE_CYC = 12'h0_014  // Window length in link cycles
) (
  input  wire logic clk_i,     // Link clock
  input  wire logic rst_n_i,   // Reset synchronised to the link clock
  input  wire logic prep_i,    // Lane entered LP-00 preparation
  output logic      mask_o     // High while lane transitions are ignored
);
  logic [11:0] cnt_reg;
  logic [11:0] cnt_next;
  logic        prep_d_reg;
  logic        mask_reg;
  wire         prep_rise = prep_i & ~prep_d_reg;
  wire         run       = (cnt_reg != 12'h0_000);

  assign cnt_next = prep_rise ? SETTLE_CYC : (run ? cnt_reg - 12'h0_001 : cnt_reg);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_reg    <= 12'h0_000;
      prep_d_reg <= 1'b0;
      mask_reg   <= 1'b0;
    end else begin
      cnt_reg    <= cnt_next;
      prep_d_reg <= prep_i;
      mask_reg   <= (cnt_next != 12'h0_000);
    end
  end

  assign mask_o = mask_reg;
endmodule

// file: rtl/dtmr_sync2.sv
// Two-flop synchroniser for a level crossing into the local clock
`timescale 1ns/1ns
module dtmr_sync2 (
  input  wire logic clk_i,     // Destination clock
  input  wire logic rst_n_i,   // Synchronous reset, active low
  input  wire logic d_i,       // Level from the other domain
  output logic      q_o        // Synchronised level
);
  logic meta_reg;
  logic q_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= 1'b0;
      q_reg    <= 1'b0;
    end else begin
      meta_reg <= d_i;
      q_reg    <= meta_reg;
    end
  end

  assign q_o = q_reg;
endmodule

// file: rtl/dtmr_top.sv
// Lane mode transition timer: transmit sequencer and receive settle masks
`timescale 1ns/1ns

// Function
// - Entry to high speed steps LP-11, LP-01, LP-00 in order before any HS state.
// - After the trail the transmitter returns the lane to LP-11.
// - The HS clock runs at least 60 ns plus 52 UI after the data trail ends.
// - The HS clock runs at least 8 UI before the data lane leaves low power.
// - Clock-lane LP-00 lasts between 38 ns and 95 ns before HS-0.
// - Receiver ignores clock-lane transitions for a 95 to 300 ns settle window.
// - Clock lane sits in HS-0 at least 60 ns after the last clock bit.
// - Clock-lane LP-00 plus HS-0 last at least 300 ns before clock toggles.
// - Data-lane LP-00 lasts between 40 ns plus 4 UI and 85 ns plus 6 UI.
// - Receiver ignores data-lane transitions for 85 ns plus 6 UI up to 145 ns plus 10 UI.
// - Data trail lasts at least max of n*8 UI and 60 ns plus n*4 UI.
// - Every low-power state driven lasts at least 50 ns.
// - Data-lane LP-00 plus HS-0 last at least 145 ns plus 10 UI before sync.
// - All settle and transmit intervals are design-time parameters.
// - Both settle timers accept settings from 40 ns to 2590 ns.
module dtmr_top #(
  parameter int UI_PS           = dphy_tmr_pkg::UI_PS_DEF,           // HS bit period, ps
  parameter int LANE_BYTES      = dphy_tmr_pkg::LANE_BYTES_DEF,      // n of the trail
  parameter int LINK_PERIOD_PS  = 12_000,                            // Link clock period, ps
  parameter int CLK_SETTLE_NS   = dphy_tmr_pkg::T_CLK_SETTLE_DEF_NS, // Clock settle window
  parameter int HS_SETTLE_NS    = dphy_tmr_pkg::T_HS_SETTLE_DEF_NS,  // Data settle window
  parameter int LPX_NS          = dphy_tmr_pkg::T_LPX_NS,            // LP state length
  parameter int CLK_PREP_NS     = 50,                                // Clock LP-00 length
  parameter int CLK_ZERO_NS     = 260,                               // Clock HS-0 length
  parameter int CLK_PRE_UI      = dphy_tmr_pkg::T_CLK_PRE_UI,        // Clock lead, UI
  parameter int CLK_POST_NS     = dphy_tmr_pkg::T_CLK_POST_NS,       // Clock tail, ns part
  parameter int CLK_POST_UI     = dphy_tmr_pkg::T_CLK_POST_UI,       // Clock tail, UI part
  parameter int CLK_TRAIL_NS    = dphy_tmr_pkg::T_CLK_TRAIL_NS,      // Clock trail
  parameter int HS_PREP_NS      = 60,                                // Data LP-00, ns part
  parameter int HS_PREP_UI      = 5,                                 // Data LP-00, UI part
  parameter int HS_ZERO_NS      = 120,                               // Data HS-0, ns part
  parameter int HS_ZERO_UI      = 10                                 // Data HS-0, UI part
) (
  input  wire logic                        clk_sys_i,     // System clock, 100 MHz
  input  wire logic                        rst_n_i,       // Synchronous reset, active low
  input  wire logic                        clk_link_i,    // Receive link clock
  input  wire logic                        tx_req_i,      // Request an HS burst, level
  input  wire logic                        tx_last_i,     // Payload done, pulse
  input  wire logic                        rx_clk_prep_i, // Clock lane in LP-00 (link dom.)
  input  wire logic                        rx_dat_prep_i, // Data lane in LP-00 (link dom.)
  output dphy_tmr_pkg::dtmr_tx_lane_t      tx_lane_o,     // Transmit lane states
  output logic                             tx_busy_o,     // Sequencer not idle
  output dphy_tmr_pkg::dtmr_rx_mask_t      rx_mask_o      // Settle masks, link domain
);

  // ==========================================================================
  // Interval counts in system cycles
  // ==========================================================================
  localparam logic [11:0] C_LPX      = dphy_tmr_pkg::ps_to_cyc(LPX_NS * 1000);
  localparam logic [11:0] C_CLK_PREP = dphy_tmr_pkg::ps_to_cyc(CLK_PREP_NS * 1000);
  localparam logic [11:0] C_CLK_ZERO = dphy_tmr_pkg::ps_to_cyc(CLK_ZERO_NS * 1000);
  localparam logic [11:0] C_CLK_PRE  = dphy_tmr_pkg::ps_to_cyc(CLK_PRE_UI * UI_PS);
  localparam logic [11:0] C_CLK_POST =
    dphy_tmr_pkg::ps_to_cyc(CLK_POST_NS * 1000 + CLK_POST_UI * UI_PS);
  localparam logic [11:0] C_CLK_TRL  = dphy_tmr_pkg::ps_to_cyc(CLK_TRAIL_NS * 1000);
  localparam logic [11:0] C_HS_PREP  =
    dphy_tmr_pkg::ps_to_cyc(HS_PREP_NS * 1000 + HS_PREP_UI * UI_PS);
  localparam logic [11:0] C_HS_ZERO  =
    dphy_tmr_pkg::ps_to_cyc(HS_ZERO_NS * 1000 + HS_ZERO_UI * UI_PS);
  localparam int TRAIL_A_PS =
    LANE_BYTES * dphy_tmr_pkg::T_HS_TRAIL_UI_A * UI_PS;
  localparam int TRAIL_B_PS = dphy_tmr_pkg::T_HS_TRAIL_NS * 1000 +
    LANE_BYTES * dphy_tmr_pkg::T_HS_TRAIL_UI_B * UI_PS;
  localparam logic [11:0] C_HS_TRL   =
    dphy_tmr_pkg::ps_to_cyc((TRAIL_A_PS > TRAIL_B_PS) ? TRAIL_A_PS : TRAIL_B_PS);

  // Settle windows in link cycles, checked against their legal ranges
  localparam logic [11:0] C_CLK_SETTLE =
    dphy_tmr_pkg::ps_to_cyc_dn(CLK_SETTLE_NS * 1000, LINK_PERIOD_PS);
  localparam logic [11:0] C_HS_SETTLE  =
    dphy_tmr_pkg::ps_to_cyc_dn(HS_SETTLE_NS * 1000, LINK_PERIOD_PS);

  // ==========================================================================
  // Parameter legality
  // ==========================================================================
  localparam int HS_PREP_TOT_PS = HS_PREP_NS * 1000 + HS_PREP_UI * UI_PS;
  localparam int HS_PREP_MIN_PS = dphy_tmr_pkg::T_HS_PREP_MIN_NS * 1000 +
    dphy_tmr_pkg::T_HS_PREP_MIN_UI * UI_PS;
  localparam int HS_PREP_MAX_PS = dphy_tmr_pkg::T_HS_PREP_MAX_NS * 1000 +
    dphy_tmr_pkg::T_HS_PREP_MAX_UI * UI_PS;
  localparam int HS_PZ_MIN_PS = dphy_tmr_pkg::T_HS_PZ_MIN_NS * 1000 +
    dphy_tmr_pkg::T_HS_PZ_MIN_UI * UI_PS;

  generate
    if (CLK_SETTLE_NS < dphy_tmr_pkg::T_SETTLE_MIN_NS ||
        CLK_SETTLE_NS > dphy_tmr_pkg::T_SETTLE_MAX_NS) begin : g_bad_clk_settle
      $error("Clock settle setting outside its range");
    end
    if (HS_SETTLE_NS < dphy_tmr_pkg::T_SETTLE_MIN_NS ||
        HS_SETTLE_NS > dphy_tmr_pkg::T_SETTLE_MAX_NS) begin : g_bad_hs_settle
      $error("Data settle setting outside its range");
    end
    if (CLK_PREP_NS < dphy_tmr_pkg::T_CLK_PREP_MIN_NS ||
        CLK_PREP_NS > dphy_tmr_pkg::T_CLK_PREP_MAX_NS) begin : g_bad_clk_prep
      $error("Clock prepare setting outside its range");
    end
    if (CLK_PREP_NS + CLK_ZERO_NS < dphy_tmr_pkg::T_CLK_PZ_MIN_NS) begin : g_bad_clk_pz
      $error("Clock prepare plus zero too short");
    end
    if (HS_PREP_TOT_PS < HS_PREP_MIN_PS ||
        HS_PREP_TOT_PS > HS_PREP_MAX_PS) begin : g_bad_hs_prep
      $error("Data prepare setting outside its range");
    end
    if (HS_PREP_TOT_PS + HS_ZERO_NS * 1000 + HS_ZERO_UI * UI_PS < HS_PZ_MIN_PS)
      begin : g_bad_hs_pz
      $error("Data prepare plus zero too short");
    end
    if (LPX_NS < dphy_tmr_pkg::T_LPX_NS) begin : g_bad_lpx
      $error("LP state length too short");
    end
  endgenerate

  // ==========================================================================
  // Transmit sequencer states
  // ==========================================================================
  typedef enum logic [3:0] {
    DTMR_S_IDLE     = 4'h0,
    DTMR_S_CLK_LP01 = 4'h1,
    DTMR_S_CLK_LP00 = 4'h3,
    DTMR_S_CLK_ZERO = 4'h2,
    DTMR_S_CLK_PRE  = 4'h6,
    DTMR_S_DAT_LP01 = 4'h7,
    DTMR_S_DAT_LP00 = 4'h5,
    DTMR_S_DAT_ZERO = 4'h4,
    DTMR_S_DAT_HS   = 4'hC,
    DTMR_S_DAT_TRL  = 4'hD,
    DTMR_S_CLK_POST = 4'hF,
    DTMR_S_CLK_TRL  = 4'hE,
    DTMR_S_LP_EXIT  = 4'hA
  } dtmr_state_t;

  dtmr_state_t                 state_reg;
  dtmr_state_t                 state_next;
  logic [11:0]                 cnt_reg;
  logic [11:0]                 cnt_next;
  logic                        last_seen_reg;
  dphy_tmr_pkg::dtmr_tx_lane_t lane_reg;
  dphy_tmr_pkg::dtmr_tx_lane_t lane_next;
  logic                        busy_reg;

  wire cnt_done  = (cnt_reg == 12'h0_001);
  wire in_hs     = (state_reg == DTMR_S_DAT_HS);
  wire trail_ok  = in_hs & (last_seen_reg | tx_last_i) & cnt_done;

  // Interval length loaded on entry to each state
  function automatic logic [11:0] load_of(input dtmr_state_t s);
    unique case (s)
      DTMR_S_CLK_LP01: load_of = C_LPX;
      DTMR_S_CLK_LP00: load_of = C_CLK_PREP;
      DTMR_S_CLK_ZERO: load_of = C_CLK_ZERO;
      DTMR_S_CLK_PRE:  load_of = C_CLK_PRE;
      DTMR_S_DAT_LP01: load_of = C_LPX;
      DTMR_S_DAT_LP00: load_of = C_HS_PREP;
      DTMR_S_DAT_ZERO: load_of = C_HS_ZERO;
      DTMR_S_DAT_TRL:  load_of = C_HS_TRL;
      DTMR_S_CLK_POST: load_of = C_CLK_POST;
      DTMR_S_CLK_TRL:  load_of = C_CLK_TRL;
      DTMR_S_LP_EXIT:  load_of = C_LPX;
      default:         load_of = 12'h0_001;
    endcase
  endfunction

  // ==========================================================================
  // Next state: each step waits for its interval to expire
  // ==========================================================================
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DTMR_S_IDLE:     if (tx_req_i && cnt_done) state_next = DTMR_S_CLK_LP01;
      DTMR_S_CLK_LP01: if (cnt_done) state_next = DTMR_S_CLK_LP00;
      DTMR_S_CLK_LP00: if (cnt_done) state_next = DTMR_S_CLK_ZERO;
      DTMR_S_CLK_ZERO: if (cnt_done) state_next = DTMR_S_CLK_PRE;
      DTMR_S_CLK_PRE:  if (cnt_done) state_next = DTMR_S_DAT_LP01;
      DTMR_S_DAT_LP01: if (cnt_done) state_next = DTMR_S_DAT_LP00;
      DTMR_S_DAT_LP00: if (cnt_done) state_next = DTMR_S_DAT_ZERO;
      DTMR_S_DAT_ZERO: if (cnt_done) state_next = DTMR_S_DAT_HS;
      DTMR_S_DAT_HS:   if (trail_ok) state_next = DTMR_S_DAT_TRL;
      DTMR_S_DAT_TRL:  if (cnt_done) state_next = DTMR_S_CLK_POST;
      DTMR_S_CLK_POST: if (cnt_done) state_next = DTMR_S_CLK_TRL;
      DTMR_S_CLK_TRL:  if (cnt_done) state_next = DTMR_S_LP_EXIT;
      DTMR_S_LP_EXIT:  if (cnt_done) state_next = DTMR_S_IDLE;
      default:         state_next = DTMR_S_IDLE;
    endcase
  end

  assign cnt_next = (state_next != state_reg) ? load_of(state_next) :
                    (cnt_reg > 12'h0_001)     ? cnt_reg - 12'h0_001 : cnt_reg;

  // ==========================================================================
  // Lane states driven in each sequencer state
  // ==========================================================================
  always_comb begin
    lane_next.clk_line  = dphy_tmr_pkg::DTMR_LP11;
    lane_next.dat_line  = dphy_tmr_pkg::DTMR_LP11;
    lane_next.hs_clk_en = 1'b0;
    lane_next.dat_ready = 1'b0;
    unique case (state_next)
      DTMR_S_CLK_LP01: lane_next.clk_line = dphy_tmr_pkg::DTMR_LP01;
      DTMR_S_CLK_LP00: lane_next.clk_line = dphy_tmr_pkg::DTMR_LP00;
      DTMR_S_CLK_ZERO: lane_next.clk_line = dphy_tmr_pkg::DTMR_HS0;
      DTMR_S_CLK_TRL:  lane_next.clk_line = dphy_tmr_pkg::DTMR_HS0;
      DTMR_S_IDLE,
      DTMR_S_LP_EXIT: begin
        lane_next.clk_line = dphy_tmr_pkg::DTMR_LP11;
      end
      default: begin
        lane_next.clk_line  = dphy_tmr_pkg::DTMR_HSTX;
        lane_next.hs_clk_en = 1'b1;
      end
    endcase
    unique case (state_next)
      DTMR_S_DAT_LP01: lane_next.dat_line = dphy_tmr_pkg::DTMR_LP01;
      DTMR_S_DAT_LP00: lane_next.dat_line = dphy_tmr_pkg::DTMR_LP00;
      DTMR_S_DAT_ZERO: lane_next.dat_line = dphy_tmr_pkg::DTMR_HS0;
      DTMR_S_DAT_HS: begin
        lane_next.dat_line  = dphy_tmr_pkg::DTMR_HSTX;
        lane_next.dat_ready = 1'b1;
      end
      DTMR_S_DAT_TRL:  lane_next.dat_line = dphy_tmr_pkg::DTMR_TRL;
      default:         lane_next.dat_line = dphy_tmr_pkg::DTMR_LP11;
    endcase
  end

  // ==========================================================================
  // Sequencer registers
  // ==========================================================================
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_reg     <= DTMR_S_IDLE;
      cnt_reg       <= C_LPX;
      last_seen_reg <= 1'b0;
      lane_reg      <= '{dphy_tmr_pkg::DTMR_LP11, dphy_tmr_pkg::DTMR_LP11, 1'b0, 1'b0};
      busy_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      last_seen_reg <= in_hs & ~trail_ok & (last_seen_reg | tx_last_i);
      lane_reg      <= lane_next;
      busy_reg      <= (state_next != DTMR_S_IDLE);
    end
  end

  assign tx_lane_o = lane_reg;
  assign tx_busy_o = busy_reg;

  // ==========================================================================
  // Receive side: settle windows on the link clock
  // ==========================================================================
  logic link_rst_n;
  logic clk_prep_s;
  logic dat_prep_s;
  logic clk_mask;
  logic dat_mask;

  dtmr_sync2 u_rst_sync (
    .clk_i   (clk_link_i),
    .rst_n_i (1'b1),
    .d_i     (rst_n_i),
    .q_o     (link_rst_n)
  );

  dtmr_sync2 u_clk_prep_sync (
    .clk_i   (clk_link_i),
    .rst_n_i (link_rst_n),
    .d_i     (rx_clk_prep_i),
    .q_o     (clk_prep_s)
  );

  dtmr_sync2 u_dat_prep_sync (
    .clk_i   (clk_link_i),
    .rst_n_i (link_rst_n),
    .d_i     (rx_dat_prep_i),
    .q_o     (dat_prep_s)
  );

  dtmr_settle #(
    .SETTLE_CYC (C_CLK_SETTLE)
  ) u_clk_settle (
    .clk_i   (clk_link_i),
    .rst_n_i (link_rst_n),
    .prep_i  (clk_prep_s),
    .mask_o  (clk_mask)
  );

  dtmr_settle #(
    .SETTLE_CYC (C_HS_SETTLE)
  ) u_dat_settle (
    .clk_i   (clk_link_i),
    .rst_n_i (link_rst_n),
    .prep_i  (dat_prep_s),
    .mask_o  (dat_mask)
  );

  assign rx_mask_o.clk_mask = clk_mask;
  assign rx_mask_o.dat_mask = dat_mask;

endmodule

// file: shared/dphy_tmr_pkg.sv
// Package: timing constants, line-state encodings and carrier structs of the D-PHY transition timer
package dphy_tmr_pkg;

  // ==========================================================================
  // Clock rates and unit interval
  // ==========================================================================
  localparam int SYS_PERIOD_PS  = 10_000;    // Counting clock, 100 MHz
  localparam int UI_PS_DEF      = 2_000;     // One high-speed bit period (500 Mb/s)
  localparam int LANE_BYTES_DEF = 1;         // n in the trail figure

  // ==========================================================================
  // Transmit interval limits, in ns and UI as printed
  // ==========================================================================
  localparam int T_LPX_NS          = 50;
  localparam int T_CLK_PREP_MIN_NS = 38;
  localparam int T_CLK_PREP_MAX_NS = 95;
  localparam int T_CLK_PZ_MIN_NS   = 300;
  localparam int T_CLK_PRE_UI      = 8;
  localparam int T_CLK_TRAIL_NS    = 60;
  localparam int T_CLK_POST_NS     = 60;
  localparam int T_CLK_POST_UI     = 52;
  localparam int T_HS_PREP_MIN_NS  = 40;
  localparam int T_HS_PREP_MIN_UI  = 4;
  localparam int T_HS_PREP_MAX_NS  = 85;
  localparam int T_HS_PREP_MAX_UI  = 6;
  localparam int T_HS_PZ_MIN_NS    = 145;
  localparam int T_HS_PZ_MIN_UI    = 10;
  localparam int T_HS_TRAIL_UI_A   = 8;
  localparam int T_HS_TRAIL_NS     = 60;
  localparam int T_HS_TRAIL_UI_B   = 4;

  // ==========================================================================
  // Receive settle windows and their legal range
  // ==========================================================================
  localparam int T_CLK_SETTLE_DEF_NS = 200;
  localparam int T_HS_SETTLE_DEF_NS  = 120;
  localparam int T_SETTLE_MIN_NS     = 40;
  localparam int T_SETTLE_MAX_NS     = 2_590;

  // ==========================================================================
  // Line states on a lane
  // ==========================================================================
  typedef enum logic [2:0] {
    DTMR_LP11 = 3'h0,
    DTMR_LP01 = 3'h1,
    DTMR_LP00 = 3'h3,
    DTMR_HS0  = 3'h2,
    DTMR_HSTX = 3'h6,
    DTMR_TRL  = 3'h7
  } dtmr_line_t;

  typedef struct packed {
    dtmr_line_t clk_line;   // Clock lane state
    dtmr_line_t dat_line;   // Data lane state
    logic       hs_clk_en;  // High-speed clock toggling
    logic       dat_ready;  // Payload may be sent on the data lane
  } dtmr_tx_lane_t;

  typedef struct packed {
    logic clk_mask;         // Ignore clock-lane HS transitions
    logic dat_mask;         // Ignore data-lane HS transitions
  } dtmr_rx_mask_t;

  // Picoseconds to cycles, rounding up, at least one cycle
  function automatic logic [11:0] ps_to_cyc(input int ps);
    int c;
    c = (ps + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
    if (c < 1) c = 1;
    return c[11:0];
  endfunction

  // Picoseconds to cycles of period per, rounding down, at least one cycle
  function automatic logic [11:0] ps_to_cyc_dn(input int ps, input int per);
    int c;
    c = ps / per;
    if (c < 1) c = 1;
    return c[11:0];
  endfunction

endpackage
